// [rtl/rptc_defs.svh]
/*
 * Constants of the reset, park and test-strap controller: timing counts,
 * field widths and reset values.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef RPTC_DEFS_SVH
`define RPTC_DEFS_SVH

// System clock period in ns
`define RPTC_CLK_PERIOD_NS 8
// Delay from power-on reset release to strap sampling, in ns
`define RPTC_STRAP_SAMPLE_NS 1500
// Strap sampling delay in clock cycles, rounded up
`define RPTC_STRAP_SAMPLE_CYC ((`RPTC_STRAP_SAMPLE_NS + `RPTC_CLK_PERIOD_NS - 1) / `RPTC_CLK_PERIOD_NS)
// Number of test strap pins
`define RPTC_STRAP_W 8
// Test-mode code meaning normal operation
`define RPTC_MODE_NORMAL 8'h00
// Output enable value that leaves every strap pin undriven
`define RPTC_OE_N_RELEASED 8'hFF
// Pull-down enables, one per strap pin, always on
`define RPTC_PD_ALL_ON 8'hFF

`endif

// [rtl/rptc_pkg.sv]
/*
 * Types of the reset, park and test-strap controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rptc_pkg;

    // Sequencer states
    typedef enum logic [2:0]
    {
        RPTC_ST_HELD = 3'b000,
        RPTC_ST_WAIT_SAMPLE = 3'b001,
        RPTC_ST_CONFIG = 3'b010,
        RPTC_ST_RUN = 3'b011,
        RPTC_ST_PARKED = 3'b100
    } rptc_state_t;

endpackage

// [rtl/rptc_delay_timer.sv]
/*
 * One-shot delay timer: a start pulse arms it, a done pulse follows
 * after CYCLES clock edges; an abort clears it.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns

module rptc_delay_timer
#(
    parameter int CYCLES = 188,
    parameter int CW = 16
)
(
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_start, // Arm the timer
    input wire logic i_abort, // Clear the timer
    output logic o_done // One-cycle pulse at expiry
);

    logic [CW-1:0] count_q;
    logic running_q;

    // Count down while running, pulse done on the last count
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || i_abort)
        begin
            count_q <= '0;
            running_q <= 1'b0;
            o_done <= 1'b0;
        end
        else if (i_start)
        begin
            count_q <= CW'(CYCLES - 1);
            running_q <= 1'b1;
            o_done <= 1'b0;
        end
        else if (running_q)
        begin
            if (count_q == '0)
            begin
                running_q <= 1'b0;
                o_done <= 1'b1;
            end
            else
            begin
                count_q <= count_q - 1'b1;
                o_done <= 1'b0;
            end
        end
        else
        begin
            o_done <= 1'b0;
        end
    end

endmodule

// [rtl/rptc_ctrl.sv]
/*
 * Pin-level reset, fast-park and test-strap controller of a display
 * controller. Starts self-configuration on release of the power-on reset,
 * samples eight test straps shortly after, then drives them as outputs, and
 * parks the mirror array on an emergency request.
 * Assumes all pin inputs are synchronous to i_sys_clk and that i_rst_n is
 * asserted once at power-up.
 */
// Notes on behaviour
// (RULE1) Rising edge of power-on reset pin starts the self-configuration sequence.
// (RULE2) While power-on reset is low, no output is in its active state.
// (RULE3) Outside party holds reset low until supplies and clocks are stable.
// (RULE4) Test pins stay undriven for as long as power-on reset is low.
// (RULE5) Test pins are sampled as mode selection about 1.5 us after release.
// (RULE6) After sampling, the test pins become driven outputs.
// (RULE7) Each test pin has a weak pull-down so open pins select normal.
// (RULE8) Outside circuitry must not pull test pins high at sampling.
// (RULE9) Fast-park input is active low and parks the mirror array quickly.
// (RULE10) Fast park is requested only when power loss is imminent.
// (RULE11) Fast park is reserved for when a normal park cannot complete.
// (RULE12) Manufacturing-test enable is held low for normal operation.
// (RULE13) Scan-port reset is held low in normal operation.
// (RULE14) Fast park overrides display activity and holds until next reset.
`timescale 1ns/1ns
`include "rptc_defs.svh"

module rptc_ctrl
#(
    parameter int STRAP_W = `RPTC_STRAP_W,
    parameter int SAMPLE_CYC = `RPTC_STRAP_SAMPLE_CYC
)
(
    input wire logic i_sys_clk, // System clock, 125 MHz
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_por_n, // Power-on reset pin, active low
    input wire logic i_fast_park_req_n, // Fast-park request pin, active low
    input wire logic i_mfg_test_enable, // Manufacturing-test enable pin
    input wire logic i_scan_port_reset_n, // Scan-port reset pin
    input wire logic [STRAP_W-1:0] i_test_strap_in, // Test strap pin levels
    input wire logic [STRAP_W-1:0] i_test_out_data, // Data to drive on strap pins
    input wire logic i_config_done, // Core finished self-configuration
    input wire logic i_park_done, // Core finished parking the array
    output logic [STRAP_W-1:0] o_test_strap_out, // Strap pin output values
    output logic [STRAP_W-1:0] o_test_strap_oe_n, // Strap pin enables, low drives
    output logic [STRAP_W-1:0] o_test_strap_pd_en, // Strap pin weak pull-down enables
    output logic [STRAP_W-1:0] o_test_mode_sel, // Sampled test-mode selection
    output logic o_normal_mode, // Sampled selection is normal operation
    output logic o_config_start, // Pulse: begin self-configuration
    output logic o_config_busy, // Self-configuration in progress
    output logic o_display_enable, // Display activity allowed
    output logic o_park_start, // Pulse: begin fast park
    output logic o_park_active, // Array parked or parking
    output logic o_strap_fault // Test enable or scan-port reset seen high in use
);

    rptc_pkg::rptc_state_t state_q;
    rptc_pkg::rptc_state_t state_d;
    logic por_q;
    logic por_rise;
    logic por_low;
    logic sample_done;
    logic park_req;

    // Power-on reset history for edge detection
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            por_q <= 1'b0;
        else
            por_q <= i_por_n;
    end

    assign por_rise = i_por_n & ~por_q; // [RULE1]
    assign por_low = ~i_por_n;
    assign park_req = ~i_fast_park_req_n; // [RULE9]

    // Strap sampling delay after reset release
    rptc_delay_timer
    #(
        .CYCLES(SAMPLE_CYC),
        .CW(16)
    )
    u_sample_timer
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_start(por_rise),
        .i_abort(por_low),
        .o_done(sample_done)
    );

    // Next-state logic of the sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rptc_pkg::RPTC_ST_HELD:
            begin
                if (por_rise)
                    state_d = rptc_pkg::RPTC_ST_WAIT_SAMPLE; // [RULE1]
            end
            rptc_pkg::RPTC_ST_WAIT_SAMPLE:
            begin
                if (park_req)
                    state_d = rptc_pkg::RPTC_ST_PARKED; // [RULE14]
                else if (sample_done)
                    state_d = rptc_pkg::RPTC_ST_CONFIG; // [RULE5]
            end
            rptc_pkg::RPTC_ST_CONFIG:
            begin
                if (park_req)
                    state_d = rptc_pkg::RPTC_ST_PARKED; // [RULE14]
                else if (i_config_done)
                    state_d = rptc_pkg::RPTC_ST_RUN;
            end
            rptc_pkg::RPTC_ST_RUN:
            begin
                if (park_req)
                    state_d = rptc_pkg::RPTC_ST_PARKED; // [RULE9]
            end
            rptc_pkg::RPTC_ST_PARKED:
            begin
                state_d = rptc_pkg::RPTC_ST_PARKED; // [RULE14]
            end
            default:
            begin
                state_d = rptc_pkg::RPTC_ST_HELD;
            end
        endcase
        if (por_low)
            state_d = rptc_pkg::RPTC_ST_HELD; // [RULE2]
    end

    // Sequencer state register
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            state_q <= rptc_pkg::RPTC_ST_HELD;
        else
            state_q <= state_d;
    end

    // Self-configuration start pulse and busy flag
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || por_low)
        begin
            o_config_start <= 1'b0; // [RULE2]
            o_config_busy <= 1'b0;
        end
        else
        begin
            o_config_start <= por_rise && state_q == rptc_pkg::RPTC_ST_HELD; // [RULE1]
            o_config_busy <= state_d == rptc_pkg::RPTC_ST_WAIT_SAMPLE
                || state_d == rptc_pkg::RPTC_ST_CONFIG;
        end
    end

    // Strap capture at the sampling point
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || por_low)
        begin
            o_test_mode_sel <= `RPTC_MODE_NORMAL;
            o_normal_mode <= 1'b0; // [RULE2]
        end
        else if (sample_done && state_q == rptc_pkg::RPTC_ST_WAIT_SAMPLE)
        begin
            o_test_mode_sel <= i_test_strap_in; // [RULE5]
            o_normal_mode <= i_test_strap_in == `RPTC_MODE_NORMAL;
        end
    end

    // Strap pin drivers: released during reset, driven once sampled
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || por_low)
        begin
            o_test_strap_oe_n <= `RPTC_OE_N_RELEASED; // [RULE4]
            o_test_strap_out <= '0;
        end
        else if (sample_done && state_q == rptc_pkg::RPTC_ST_WAIT_SAMPLE)
        begin
            o_test_strap_oe_n <= '0; // [RULE6]
            o_test_strap_out <= i_test_out_data;
        end
        else if (o_test_strap_oe_n == '0)
        begin
            o_test_strap_out <= i_test_out_data; // [RULE6]
        end
    end

    // Weak pull-downs on every strap pin
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_test_strap_pd_en <= `RPTC_PD_ALL_ON;
        else
            o_test_strap_pd_en <= `RPTC_PD_ALL_ON; // [RULE7]
    end

    // Display enable, dropped at once by a park request
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_display_enable <= 1'b0;
        else
            o_display_enable <= state_d == rptc_pkg::RPTC_ST_RUN && !park_req; // [RULE14]
    end

    // Fast-park start pulse and sticky park status
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || por_low)
        begin
            o_park_start <= 1'b0; // [RULE2]
            o_park_active <= 1'b0;
        end
        else
        begin
            o_park_start <= state_q != rptc_pkg::RPTC_ST_PARKED
                && state_q != rptc_pkg::RPTC_ST_HELD
                && state_d == rptc_pkg::RPTC_ST_PARKED; // [RULE9]
            o_park_active <= state_d == rptc_pkg::RPTC_ST_PARKED; // [RULE14]
        end
    end

    // Fault flag when test or scan controls are not held low in use
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || por_low)
            o_strap_fault <= 1'b0;
        else if (state_q != rptc_pkg::RPTC_ST_HELD && (i_mfg_test_enable || i_scan_port_reset_n))
            o_strap_fault <= 1'b1; // [RULE12] [RULE13]
    end

    // Completion of parking is not needed for the sticky park state
    logic park_done_unused;
    assign park_done_unused = i_park_done;

endmodule

// [sim/rptc_ctrl_props.sv]
/* Port checker of the reset, park and strap controller.
   Assumes binding into rptc_ctrl by port name. */
`timescale 1ns/1ns
module rptc_ctrl_props
#(
    parameter int STRAP_W = 8,
    parameter int SAMPLE_CYC = 188
)
(
    input wire logic i_sys_clk, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_por_n, // Power-on reset
    input wire logic i_fast_park_req_n, // Park request
    input wire logic [STRAP_W-1:0] i_test_out_data, // Strap data
    input wire logic [STRAP_W-1:0] o_test_strap_out, // Strap out
    input wire logic [STRAP_W-1:0] o_test_strap_oe_n, // Strap enables
    input wire logic [STRAP_W-1:0] o_test_strap_pd_en, // Pull-downs
    input wire logic [STRAP_W-1:0] o_test_mode_sel, // Mode
    input wire logic o_normal_mode, // Normal mode
    input wire logic o_config_start, // Config pulse
    input wire logic o_config_busy, // Config busy
    input wire logic o_display_enable, // Display on
    input wire logic o_park_start, // Park pulse
    input wire logic o_park_active // Parked
);
    int cnt_q;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Counts cycles since power-on reset release, saturating
    always_ff @(posedge i_sys_clk)
        if (!i_rst_n || !i_por_n)
            cnt_q <= 0;
        else if (cnt_q < SAMPLE_CYC + 2)
            cnt_q <= cnt_q + 1;
    // Relations between pins and status
    property p_held; !i_por_n |=> o_test_strap_oe_n == 8'hFF && !o_config_busy && !o_park_active; endproperty
    property p_pd; o_test_strap_pd_en == 8'hFF; endproperty
    property p_start; i_por_n && !$past(i_por_n) |-> ##[0:2] o_config_start; endproperty
    property p_pulse; o_config_start |-> o_config_busy ##1 !o_config_start; endproperty
    property p_wait; o_test_strap_oe_n != 8'hFF |-> cnt_q == SAMPLE_CYC + 2; endproperty
    property p_drive;
        o_test_strap_oe_n == 8'h00 |-> o_test_strap_out == $past(i_test_out_data)
            && o_normal_mode == (o_test_mode_sel == 8'h00);
    endproperty
    property p_park;
        (o_config_busy || o_display_enable) && i_por_n && $past(i_por_n) && !i_fast_park_req_n
            |=> o_park_start && o_park_active && !o_display_enable;
    endproperty
    property p_sticky; o_park_active && i_por_n |=> o_park_active; endproperty
    a_held: assert property (p_held) else $error("active during reset");
    a_pd: assert property (p_pd) else $error("pull-down off");
    a_start: assert property (p_start) else $error("no config start");
    a_pulse: assert property (p_pulse) else $error("bad config pulse");
    a_wait: assert property (p_wait) else $error("straps driven early");
    a_drive: assert property (p_drive) else $error("bad strap drive");
    a_park: assert property (p_park) else $error("no fast park");
    a_sticky: assert property (p_sticky) else $error("park lost");
    c_start: cover property (o_config_start);
    c_drive: cover property (o_test_strap_oe_n == 8'h00);
    c_park: cover property (o_park_start);
endmodule

bind rptc_ctrl rptc_ctrl_props #(.STRAP_W(STRAP_W), .SAMPLE_CYC(SAMPLE_CYC)) u_props (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_fast_park_req_n(i_fast_park_req_n),
    .i_test_out_data(i_test_out_data), .o_test_strap_out(o_test_strap_out), .o_test_strap_oe_n(o_test_strap_oe_n),
    .o_test_strap_pd_en(o_test_strap_pd_en), .o_test_mode_sel(o_test_mode_sel), .o_normal_mode(o_normal_mode),
    .o_config_start(o_config_start), .o_config_busy(o_config_busy), .o_display_enable(o_display_enable),
    .o_park_start(o_park_start), .o_park_active(o_park_active));

// [sim/rptc_pmic_model.sv]
/* Power-management partner: drives power-on reset and fast park,
   and resolves the strap pins. Assumes bench-held commands. */
`timescale 1ns/1ns
module rptc_pmic_model
(
    input wire logic i_rails_ok, // Supplies and clocks stable
    input wire logic i_power_fail, // Power loss imminent
    input wire logic i_ext_en, // Board drives straps
    input wire logic [7:0] i_ext_lvl, // Board strap level
    input wire logic [7:0] i_oe_n, // Device strap enables
    input wire logic [7:0] i_out, // Device strap values
    output logic o_por_n, // Power-on reset
    output logic o_park_n, // Fast-park request
    output logic [7:0] o_lvl // Strap wire levels
);
    // Reset stays low until rails are good
    assign o_por_n = i_rails_ok;
    // Fast park only on imminent power loss
    assign o_park_n = !i_power_fail;
    // Device drive wins, then board, else weak pull-down
    assign o_lvl = (~i_oe_n & i_out) | (i_oe_n & i_ext_lvl & {8{i_ext_en}});
endmodule

// [sim/tb_top.sv]
/* Bench of the reset, park and strap controller.
   Assumes the partner model and a 125 MHz clock. */
`timescale 1ns/1ns
module tb_top;
    localparam int S = 8;
    logic i_sys_clk, i_rst_n, ok, fail, ext_en, i_config_done, o_normal_mode;
    logic o_config_start, o_config_busy, o_display_enable, o_park_start, o_park_active;
    logic i_por_n, i_fast_park_req_n;
    logic o_strap_fault, mfg_en, scan_rst;
    logic [7:0] ext, i_test_out_data, i_test_strap_in, o_test_strap_out;
    logic [7:0] o_test_strap_oe_n, o_test_strap_pd_en, o_test_mode_sel;
    int mismatches, num_checks, cyc;
    wire logic [7:0] st = {3'h0, o_config_start, o_config_busy, o_display_enable, o_park_start, o_park_active};
    // Both must-be-low pins are held low except in the fault scenario
    rptc_ctrl #(.SAMPLE_CYC(S)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
        .i_fast_park_req_n(i_fast_park_req_n), .i_mfg_test_enable(mfg_en), .i_scan_port_reset_n(scan_rst),
        .i_test_strap_in(i_test_strap_in), .i_test_out_data(i_test_out_data), .i_config_done(i_config_done),
        .i_park_done(1'b0), .o_test_strap_out(o_test_strap_out), .o_test_strap_oe_n(o_test_strap_oe_n),
        .o_test_strap_pd_en(o_test_strap_pd_en), .o_test_mode_sel(o_test_mode_sel), .o_normal_mode(o_normal_mode),
        .o_config_start(o_config_start), .o_config_busy(o_config_busy), .o_display_enable(o_display_enable),
        .o_park_start(o_park_start), .o_park_active(o_park_active), .o_strap_fault(o_strap_fault));
    rptc_pmic_model pmic (.i_rails_ok(ok), .i_power_fail(fail), .i_ext_en(ext_en), .i_ext_lvl(ext),
        .i_oe_n(o_test_strap_oe_n), .i_out(o_test_strap_out), .o_por_n(i_por_n),
        .o_park_n(i_fast_park_req_n), .o_lvl(i_test_strap_in));
    // Clock
    initial
    begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // Compares and counts
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Releases reset and waits for the config pulse
    task automatic release_wait();
        int n;
        n = 0;
        ok = 1'b1;
        while (o_config_start !== 1'b1 && n < 4)
        begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask
    // Power-up with board straps, sampling and configuration
    task automatic t_boot(input logic en, input logic [7:0] v);
        logic [7:0] m;
        m = en ? v : 8'h00;
        ok = 1'b0;
        ext_en = en;
        ext = v;
        i_test_out_data = ~m;
        repeat (3) @(negedge i_sys_clk);
        chk(st, 8'h00);
        chk(o_test_strap_oe_n, 8'hFF);
        release_wait();
        chk(st, 8'h18);
        repeat (S) @(negedge i_sys_clk);
        chk(o_test_strap_oe_n, 8'hFF);
        @(negedge i_sys_clk);
        chk(o_test_strap_oe_n, 8'h00);
        chk(o_test_mode_sel, m);
        chk(8'(o_normal_mode), 8'(m == 8'h00));
        chk(i_test_strap_in, ~m);
        i_config_done = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        i_config_done = 1'b0;
        chk(st, 8'h04);
    endtask
    // Fast park while the display runs
    task automatic t_park_run();
        fail = 1'b1;
        @(negedge i_sys_clk);
        chk(st, 8'h03);
        fail = 1'b0;
        @(negedge i_sys_clk);
        chk(st, 8'h01);
    endtask
    // Park request in reset is ignored; park before sampling skips it
    task automatic t_park_early();
        ok = 1'b0;
        fail = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk(st, 8'h00);
        fail = 1'b0;
        release_wait();
        fail = 1'b1;
        @(negedge i_sys_clk);
        fail = 1'b0;
        chk(st, 8'h03);
        repeat (S + 2) @(negedge i_sys_clk);
        chk(st, 8'h01);
        chk(o_test_strap_oe_n, 8'hFF);
    endtask
    // Must-be-low pins seen high outside reset raise the sticky fault flag
    task automatic t_fault();
        chk(8'(o_strap_fault), 8'h00);
        mfg_en = 1'b1;
        @(negedge i_sys_clk);
        mfg_en = 1'b0;
        @(negedge i_sys_clk);
        chk(8'(o_strap_fault), 8'h01);
        ok = 1'b0;
        scan_rst = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk(8'(o_strap_fault), 8'h00);
        ok = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk(8'(o_strap_fault), 8'h01);
        scan_rst = 1'b0;
    endtask
    // Main sequence
    initial
    begin
        i_rst_n = 1'b0;
        {ok, fail, ext_en, i_config_done} = 4'h0;
        {mfg_en, scan_rst} = 2'b00;
        ext = 8'h00;
        i_test_out_data = 8'h00;
        repeat (12) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        chk(o_test_strap_pd_en, 8'hFF);
        t_boot(1'b0, 8'hA5);
        t_park_run();
        t_boot(1'b1, 8'hA5);
        t_park_early();
        t_fault();
        conclude();
    end
    // Cuts a hang short
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            mismatches++;
            conclude();
        end
    end
endmodule
